// >>> rtl/ies_pkg.sv
// Purpose: Shared constants for the interrupt event sources block
// Assumes: 40 MHz ref_clk, 8-bit device registers
// Notes:   Times are in ns, cycle counts derive from them
package ies_pkg;
    localparam int CLK_NS        = 25;
    localparam int SE0_MIN_NS    = 12000;
    localparam int T128_NS       = 128000;
    localparam int T1024_NS      = 1024000;
    localparam int STARTUP_NS    = 100000;
    // Least time rounds up, periods are exact
    localparam int SE0_CYC     = (SE0_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int T128_CYC    = T128_NS / CLK_NS;
    localparam int T1024_CYC   = T1024_NS / CLK_NS;
    localparam int STARTUP_CYC = STARTUP_NS / CLK_NS;

    localparam logic [7:0] A_ADDR_A   = 8'h10;
    localparam logic [7:0] A_ADDR_B   = 8'h40;
    localparam logic [7:0] A_ATTACH   = 8'h48;
    localparam logic [7:0] A_EN_MASK  = 8'h49;
    localparam logic [7:0] A_RATE     = 8'h4A;
    localparam logic [7:0] A_SLEEP    = 8'h4D;
    localparam logic [7:0] A_WAKE     = 8'h4E;
    localparam logic [7:0] A_LINE0    = 8'h4F;
    localparam logic [7:0] A_LINEV    = 8'h50;
    localparam logic [7:0] A_FORCE    = 8'h51;
    localparam logic [7:0] A_PSC      = 8'h1F;
    localparam logic [7:0] A_GIE      = 8'h20;
    localparam logic [7:0] A_EPIE     = 8'h21;
    localparam logic [7:0] A_PEND_LO  = 8'h22;
    localparam logic [7:0] A_PEND_HI  = 8'h23;
    localparam logic [7:0] A_SERVICE  = 8'h24;
    localparam logic [7:0] A_VECTOR   = 8'h25;
    localparam logic [7:0] A_I2C_CTL  = 8'h28;
    localparam logic [7:0] A_I2C_STS  = 8'h29;
    localparam logic [7:0] A_GPIO_EN  = 8'h2C;
    localparam logic [7:0] A_GPIO_POL = 8'h2D;

    localparam int PSC_BUSRST = 5;
    // Global enable bits
    localparam int GE_BUSRST = 0;
    localparam int GE_T128   = 1;
    localparam int GE_T1024  = 2;
    localparam int GE_HUB    = 3;
    localparam int GE_GPIO   = 5;
    localparam int GE_I2C    = 6;
    // Two-wire control and status bits
    localparam int IC_PROCEED = 0;
    localparam int IC_MASTER  = 1;
    localparam int IC_ACK     = 2;
    localparam int IC_XMIT    = 3;
    localparam int IS_FIRST   = 0;
    localparam int IS_STOP    = 1;
    localparam int IS_ARBLOST = 2;
    localparam int IS_ACKRX   = 3;
    localparam int NUM_VEC    = 12;
endpackage : ies_pkg

// >>> rtl/ies_if.sv
// Purpose: Register and interrupt path between controller and device
// Assumes: Both ends on ref_clk
// Notes:   Strobes are one-cycle pulses
`timescale 1ns/100ps
interface ies_if;
    logic       reg_wr;     // Write strobe
    logic       reg_rd;     // Read strobe
    logic [7:0] reg_addr;   // Register address
    logic [7:0] reg_wdata;  // Write data
    logic [7:0] reg_rdata;  // Read data
    logic       reg_rvalid; // Read data valid pulse
    logic       irq;        // Enabled request pending
    logic [3:0] irq_vec;    // Highest request vector
    modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata,
                 output reg_rdata, reg_rvalid, irq, irq_vec);
    modport ctl (output reg_wr, reg_rd, reg_addr, reg_wdata,
                 input reg_rdata, reg_rvalid, irq, irq_vec);
endinterface : ies_if

// >>> rtl/ies_device.sv
// Purpose: Interrupt event sources: bus reset, timers, endpoints, hub,
//          pins and two-wire controller events into pending flags
// Assumes: Event inputs synchronous to ref_clk, pulses one cycle
// Notes:   Hardware sets win over firmware clears in the same cycle
//
// How it works
// - SE0 of 12 us counts as bus reset
// - Bus reset sets status bit 5
// - Bus reset clears both device addresses
// - Bus reset clears hub registers 0x48..0x51
// - Bus reset request raised when SE0 ends
// - Bus reset aborts start-up delay
// - Two free periodic timer sources
// - Five endpoint sources, one each
// - Endpoint fires on acknowledged handshake only
// - Hub request on connect, babble, resume
// - Babble and resume gated by port enable
// - Forced ports raise no connect request
// - Each enabled pin interrupts, one polarity, one vector
// - Owning pin locks out others until released
// - Lowest active pin takes the lock, pin enables kept
// - Slave receive byte interrupts, first-byte flag
// - Slave receive: stop seen flagged unless ack was cleared
// - Slave transmit byte interrupts with master ack
// - Master transmit: clearing master select stops
// - Master receive: clearing master select stops
// - Arbitration loss: drop master, await stop
// - Proceed cleared before byte interrupts
// - Each source latches a pending flag
// - Lowest vector number wins
`timescale 1ns/100ps
module ies_device #(
    parameter int T128_CYC    = ies_pkg::T128_CYC,   // Short timer period
    parameter int T1024_CYC   = ies_pkg::T1024_CYC,  // Long timer period
    parameter int STARTUP_CYC = ies_pkg::STARTUP_CYC // Start-up delay
) (
    input  wire logic       ref_clk,        // 40 MHz clock
    input  wire logic       sys_rst,        // Sync reset, high
    ies_if.dev              fw,             // Firmware register path
    input  wire logic       usb_se0,        // Upstream SE0 level
    input  wire logic [4:0] ep_hs,          // Endpoint final handshake
    input  wire logic       ep_hs_acked,    // Handshake was an ACK
    input  wire logic [3:0] hub_conn_chg,   // Downstream connect change
    input  wire logic [3:0] hub_babble,     // Babble seen per port
    input  wire logic [3:0] hub_resume,     // Resume seen per port
    input  wire logic [7:0] gpio_pin,       // Pin levels
    input  wire logic       i2c_byte_done,  // Byte moved on two-wire
    input  wire logic       i2c_first,      // Byte follows start
    input  wire logic       i2c_ack_in,     // Master acked our byte
    input  wire logic       i2c_stop,       // Stop seen on bus
    input  wire logic       i2c_arb_lost,   // Arbitration lost
    output logic            i2c_proceed,    // Proceed/busy level
    output logic            i2c_stop_req,   // Send stop, pulse
    output logic            startup_busy    // Start-up delay running
);
    typedef struct packed {
        logic [7:0]  addr_a, addr_b, attach, en_mask, rate, sleep;
        logic [7:0]  wake, line0, linev, force_q;
        logic [7:0]  psc, gie, epie, gpio_en, i2c_ctl, i2c_sts;
        logic        gpio_pol, gpio_lock;
        logic [2:0]  gpio_own;
        logic        i2c_fire, arb_wait, stop_req;
        logic [9:0]  se0_cnt;
        logic        bus_rst;
        logic [15:0] t128, t1024, start_cnt;
        logic        busy;
        logic [11:0] pend;
        logic [7:0]  rdata;
        logic        rvalid, irq;
        logic [3:0]  vec;
    } ies_dev_s;

    ies_dev_s   s_q, s_d;
    logic [11:0] en_vec;
    logic [7:0]  pin_act;
    logic        hub_evt;
    logic        slave_rx;

    // Request enables in vector order, DAC slot has no source
    assign en_vec = {s_q.gie[ies_pkg::GE_I2C], s_q.gie[ies_pkg::GE_GPIO],
                     1'b0, s_q.gie[ies_pkg::GE_HUB], s_q.epie[4:0],
                     s_q.gie[ies_pkg::GE_T1024], s_q.gie[ies_pkg::GE_T128],
                     s_q.gie[ies_pkg::GE_BUSRST]};
    assign pin_act = (s_q.gpio_pol ? gpio_pin : ~gpio_pin) & s_q.gpio_en;
    assign hub_evt = |(hub_conn_chg & ~s_q.force_q[3:0])
                   | |((hub_babble | hub_resume) & s_q.en_mask[3:0]);
    assign slave_rx = !s_q.i2c_ctl[ies_pkg::IC_MASTER]
                   && !s_q.i2c_ctl[ies_pkg::IC_XMIT];

    // Next state: firmware writes first, hardware events after
    always_comb begin
        s_d = s_q;
        s_d.rvalid   = 1'b0;
        s_d.stop_req = 1'b0;
        s_d.i2c_fire = 1'b0;
        if (fw.reg_wr) begin
            unique case (fw.reg_addr)
                ies_pkg::A_ADDR_A:   s_d.addr_a   = fw.reg_wdata;
                ies_pkg::A_ADDR_B:   s_d.addr_b   = fw.reg_wdata;
                ies_pkg::A_ATTACH:   s_d.attach   = fw.reg_wdata;
                ies_pkg::A_EN_MASK:  s_d.en_mask  = fw.reg_wdata;
                ies_pkg::A_RATE:     s_d.rate     = fw.reg_wdata;
                ies_pkg::A_SLEEP:    s_d.sleep    = fw.reg_wdata;
                ies_pkg::A_WAKE:     s_d.wake     = fw.reg_wdata;
                ies_pkg::A_LINE0:    s_d.line0    = fw.reg_wdata;
                ies_pkg::A_LINEV:    s_d.linev    = fw.reg_wdata;
                ies_pkg::A_FORCE:    s_d.force_q  = fw.reg_wdata;
                ies_pkg::A_PSC:      s_d.psc      = s_q.psc & ~fw.reg_wdata;
                ies_pkg::A_GIE:      s_d.gie      = fw.reg_wdata;
                ies_pkg::A_EPIE:     s_d.epie     = fw.reg_wdata;
                ies_pkg::A_GPIO_EN:  s_d.gpio_en  = fw.reg_wdata;
                ies_pkg::A_GPIO_POL: s_d.gpio_pol = fw.reg_wdata[0];
                ies_pkg::A_I2C_STS:  s_d.i2c_sts  = s_q.i2c_sts & ~fw.reg_wdata;
                ies_pkg::A_SERVICE: begin
                    // Acknowledge clears only the serviced flag
                    if (fw.reg_wdata >= 8'h01 && fw.reg_wdata <= 8'h0C)
                        s_d.pend[fw.reg_wdata[3:0] - 4'h1] = 1'b0;
                end
                ies_pkg::A_I2C_CTL: begin
                    s_d.i2c_ctl = fw.reg_wdata;
                    // Dropping master select while master sends stop
                    if (s_q.i2c_ctl[ies_pkg::IC_MASTER]
                        && !fw.reg_wdata[ies_pkg::IC_MASTER])
                        s_d.stop_req = 1'b1;
                end
                default: ;
            endcase
        end
        // Upstream SE0 length, detect at the 12 us point
        if (usb_se0) begin
            if (s_q.se0_cnt != 10'(ies_pkg::SE0_CYC))
                s_d.se0_cnt = s_q.se0_cnt + 10'h001;
        end else begin
            s_d.se0_cnt = 10'h000;
        end
        if (usb_se0 && s_q.se0_cnt == 10'(ies_pkg::SE0_CYC - 1))
            s_d.bus_rst = 1'b1;
        if (s_d.bus_rst) begin
            s_d.psc[ies_pkg::PSC_BUSRST] = 1'b1;
            s_d.addr_a = 8'h00;
            s_d.addr_b = 8'h00;
            s_d.attach = 8'h00;
            s_d.en_mask = 8'h00;
            s_d.rate = 8'h00;
            s_d.sleep = 8'h00;
            s_d.wake = 8'h00;
            s_d.line0 = 8'h00;
            s_d.linev = 8'h00;
            s_d.force_q = 8'h00;
            s_d.busy = 1'b0;
            s_d.start_cnt = 16'h0000;
        end
        // Request only once the reset condition lets go
        if (s_q.bus_rst && !usb_se0) begin
            s_d.bus_rst = 1'b0;
            s_d.pend[0] = 1'b1;
        end
        // Start-up delay after power-on reset
        if (s_q.busy && !s_d.bus_rst) begin
            if (s_q.start_cnt == 16'(STARTUP_CYC - 1))
                s_d.busy = 1'b0;
            else
                s_d.start_cnt = s_q.start_cnt + 16'h0001;
        end
        // Free-running periodic ticks
        s_d.t128  = s_q.t128 + 16'h0001;
        s_d.t1024 = s_q.t1024 + 16'h0001;
        if (s_q.t128 == 16'(T128_CYC - 1)) begin
            s_d.t128 = 16'h0000;
            s_d.pend[1] = 1'b1;
        end
        if (s_q.t1024 == 16'(T1024_CYC - 1)) begin
            s_d.t1024 = 16'h0000;
            s_d.pend[2] = 1'b1;
        end
        // Endpoints: an unacknowledged IN gives nothing
        if (ep_hs_acked)
            s_d.pend[7:3] = s_d.pend[7:3] | ep_hs;
        if (hub_evt)
            s_d.pend[8] = 1'b1;
        // Pin lockout: the owner blocks others until it lets go
        if (s_q.gpio_lock && !pin_act[s_q.gpio_own])
            s_d.gpio_lock = 1'b0;
        if (!s_q.gpio_lock && |pin_act) begin
            s_d.gpio_lock = 1'b1;
            s_d.pend[10]  = 1'b1;
            for (int i = 7; i >= 0; i--)
                if (pin_act[i])
                    s_d.gpio_own = 3'(i);
        end
        // Two-wire events: proceed drops a cycle before the request
        if (i2c_byte_done) begin
            s_d.i2c_ctl[ies_pkg::IC_PROCEED] = 1'b0;
            s_d.i2c_fire = 1'b1;
            if (slave_rx)
                s_d.i2c_sts[ies_pkg::IS_FIRST] = i2c_first;
            s_d.i2c_sts[ies_pkg::IS_ACKRX] = i2c_ack_in;
        end
        if (i2c_stop && slave_rx && s_q.i2c_ctl[ies_pkg::IC_ACK]) begin
            s_d.i2c_sts[ies_pkg::IS_STOP] = 1'b1;
            s_d.pend[11] = 1'b1;
        end
        if (i2c_arb_lost) begin
            s_d.i2c_ctl[ies_pkg::IC_MASTER] = 1'b0;
            s_d.i2c_sts[ies_pkg::IS_ARBLOST] = 1'b1;
            s_d.arb_wait = 1'b1;
        end else if (s_q.arb_wait && i2c_stop) begin
            s_d.arb_wait = 1'b0;
            s_d.pend[11] = 1'b1;
        end
        if (s_q.i2c_fire)
            s_d.pend[11] = 1'b1;
        s_d.pend[9] = 1'b0;
        // Lowest enabled vector number wins
        s_d.irq = |(s_q.pend & en_vec);
        s_d.vec = 4'h0;
        for (int v = ies_pkg::NUM_VEC - 1; v >= 0; v--)
            if (s_q.pend[v] && en_vec[v])
                s_d.vec = 4'(v + 1);
        // Register read port
        if (fw.reg_rd) begin
            s_d.rvalid = 1'b1;
            unique case (fw.reg_addr)
                ies_pkg::A_ADDR_A:   s_d.rdata = s_q.addr_a;
                ies_pkg::A_ADDR_B:   s_d.rdata = s_q.addr_b;
                ies_pkg::A_ATTACH:   s_d.rdata = {4'h0, s_q.attach[3:0]};
                ies_pkg::A_EN_MASK:  s_d.rdata = s_q.en_mask;
                ies_pkg::A_RATE:     s_d.rdata = s_q.rate;
                ies_pkg::A_SLEEP:    s_d.rdata = s_q.sleep;
                ies_pkg::A_WAKE:     s_d.rdata = s_q.wake;
                ies_pkg::A_LINE0:    s_d.rdata = s_q.line0;
                ies_pkg::A_LINEV:    s_d.rdata = s_q.linev;
                ies_pkg::A_FORCE:    s_d.rdata = s_q.force_q;
                ies_pkg::A_PSC:      s_d.rdata = s_q.psc;
                ies_pkg::A_GIE:      s_d.rdata = s_q.gie;
                ies_pkg::A_EPIE:     s_d.rdata = s_q.epie;
                ies_pkg::A_PEND_LO:  s_d.rdata = s_q.pend[7:0];
                ies_pkg::A_PEND_HI:  s_d.rdata = {4'h0, s_q.pend[11:8]};
                ies_pkg::A_VECTOR:   s_d.rdata = {4'h0, s_q.vec};
                ies_pkg::A_I2C_CTL:  s_d.rdata = s_q.i2c_ctl;
                ies_pkg::A_I2C_STS:  s_d.rdata = s_q.i2c_sts;
                ies_pkg::A_GPIO_EN:  s_d.rdata = s_q.gpio_en;
                ies_pkg::A_GPIO_POL: s_d.rdata = {7'h00, s_q.gpio_pol};
                default:             s_d.rdata = 8'h00;
            endcase
        end
    end

    // State register; start-up delay begins at reset release
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q      <= '0;
            s_q.busy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign fw.reg_rdata  = s_q.rdata;
    assign fw.reg_rvalid = s_q.rvalid;
    assign fw.irq        = s_q.irq;
    assign fw.irq_vec    = s_q.vec;
    assign i2c_proceed   = s_q.i2c_ctl[ies_pkg::IC_PROCEED];
    assign i2c_stop_req  = s_q.stop_req;
    assign startup_busy  = s_q.busy;
endmodule : ies_device

// >>> rtl/ies_ctrl.sv
// Purpose: AXI4-Lite slave giving software the device registers
// Assumes: Device answers a read strobe one cycle later
// Notes:   Word address bits [9:2] select the device register
`timescale 1ns/100ps
module ies_ctrl (
    input  wire logic        ref_clk,        // 40 MHz clock
    input  wire logic        sys_rst,        // Sync reset, high
    ies_if.ctl               dv,             // Device register path
    input  wire logic [31:0] s_axi_awaddr,   // Write address
    input  wire logic        s_axi_awvalid,  // Write address valid
    output logic             s_axi_awready,  // Write address ready
    input  wire logic [31:0] s_axi_wdata,    // Write data
    input  wire logic [3:0]  s_axi_wstrb,    // Byte enables
    input  wire logic        s_axi_wvalid,   // Write data valid
    output logic             s_axi_wready,   // Write data ready
    output logic [1:0]       s_axi_bresp,    // Write response
    output logic             s_axi_bvalid,   // Write response valid
    input  wire logic        s_axi_bready,   // Write response ready
    input  wire logic [31:0] s_axi_araddr,   // Read address
    input  wire logic        s_axi_arvalid,  // Read address valid
    output logic             s_axi_arready,  // Read address ready
    output logic [31:0]      s_axi_rdata,    // Read data
    output logic [1:0]       s_axi_rresp,    // Read response
    output logic             s_axi_rvalid,   // Read data valid
    input  wire logic        s_axi_rready,   // Read data ready
    output logic             irq_out,        // Enabled request pending
    output logic [3:0]       irq_vec_out     // Highest request vector
);
    typedef struct packed {
        logic        aw_h, w_h, bvalid, arbusy, rvalid, wr, rd;
        logic        wbad, rbad;
        logic [7:0]  waddr, wdata, raddr;
        logic [31:0] rdata;
        logic [1:0]  bresp, rresp;
        logic        irq;
        logic [3:0]  vec;
    } ies_ctl_s;

    ies_ctl_s s_q, s_d;

    // Address and data taken in either order, response after both
    always_comb begin
        s_d = s_q;
        s_d.wr  = 1'b0;
        s_d.rd  = 1'b0;
        s_d.irq = dv.irq;
        s_d.vec = dv.irq_vec;
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_h  = 1'b1;
            s_d.waddr = s_axi_awaddr[9:2];
            s_d.wbad  = |s_axi_awaddr[31:10];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_h   = 1'b1;
            s_d.wdata = s_axi_wdata[7:0];
            // Register lives in lane 0; other lanes are ignored
            if (!s_axi_wstrb[0])
                s_d.wbad = s_d.wbad | 1'b0;
        end
        if (s_q.aw_h && s_q.w_h && !s_q.bvalid) begin
            s_d.aw_h   = 1'b0;
            s_d.w_h    = 1'b0;
            s_d.wr     = !s_q.wbad;
            s_d.bvalid = 1'b1;
            s_d.bresp  = s_q.wbad ? 2'h2 : 2'h0;
            s_d.wbad   = 1'b0;
        end
        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;
        // Reads: one in flight, bad address answers at once
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.arbusy = 1'b1;
            s_d.raddr  = s_axi_araddr[9:2];
            s_d.rbad   = |s_axi_araddr[31:10];
            s_d.rd     = !s_d.rbad;
            if (s_d.rbad) begin
                s_d.rvalid = 1'b1;
                s_d.rdata  = 32'h0000_0000;
                s_d.rresp  = 2'h2;
            end
        end
        if (dv.reg_rvalid && s_q.arbusy) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = {24'h00_0000, dv.reg_rdata};
            s_d.rresp  = 2'h0;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
            s_d.arbusy = 1'b0;
        end
    end

    // Ready flags registered from next state
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q           <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_q           <= s_d;
            s_axi_awready <= !s_d.aw_h && !s_d.bvalid;
            s_axi_wready  <= !s_d.w_h && !s_d.bvalid;
            s_axi_arready <= !s_d.arbusy;
        end
    end

    assign dv.reg_wr     = s_q.wr;
    assign dv.reg_rd     = s_q.rd;
    assign dv.reg_addr   = s_q.wr ? s_q.waddr : s_q.raddr;
    assign dv.reg_wdata  = s_q.wdata;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign irq_out       = s_q.irq;
    assign irq_vec_out   = s_q.vec;
endmodule : ies_ctrl

// >>> verification/ies_sva.sv
// Purpose: Checks on the register and request path
// Assumes: One clock, sync reset high
// Notes:   Sees ies_if signals only
`timescale 1ns/100ps
module ies_sva (
    input wire logic       ref_clk,    // Clock
    input wire logic       sys_rst,    // Reset
    input wire logic       reg_wr,     // Write strobe
    input wire logic       reg_rd,     // Read strobe
    input wire logic       reg_rvalid, // Read valid
    input wire logic       irq,        // Request
    input wire logic [3:0] irq_vec     // Vector
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Strobes are single pulses, reads answered next cycle
    a_rd_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read data without request");
    a_rd_pulse: assert property (reg_rd |=> !reg_rd)
        else $error("read strobe too long");
    a_wr_pulse: assert property (reg_wr |=> !reg_wr)
        else $error("write strobe too long");
    // Vector tracks the request level
    a_vec_range: assert property (irq |-> irq_vec inside {[1:12]})
        else $error("vector out of range");
    a_vec_idle: assert property (!irq |-> irq_vec == 4'h0)
        else $error("vector without request");
    a_vec_no_dac: assert property (irq_vec != 4'hA)
        else $error("unused vector raised");
    a_reset_quiet: assert property ($fell(sys_rst) |-> !irq)
        else $error("request right after reset");
    cover property (reg_rd ##1 reg_rvalid);
    cover property (irq && irq_vec == 4'h1);
    cover property (irq && irq_vec == 4'h2);
endmodule : ies_sva

// >>> verification/test_interrupt_event_sources.sv
// Purpose: Bench joining device and controller ends
// Assumes: Short timer and start-up counts
// Notes:   Software side driven over AXI4-Lite
`timescale 1ns/100ps
module test_interrupt_event_sources;
    typedef struct packed {logic [7:0] a, d, e;} ies_row_s;
    logic        ref_clk = 0, sys_rst = 1, awvalid = 0, wvalid = 0;
    logic        bready = 0, arvalid = 0, rready = 0, se0 = 0, acked = 0;
    logic        bdone = 0, first = 0, istop = 0, arb = 0, stop_seen = 0;
    logic        awready, wready, bvalid, arready, rvalid, irq_out;
    logic        proceed, stop_req, busy, ackin = 0;
    logic [1:0]  bresp, rresp;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic [3:0]  irq_vec, conn = 0, babble = 0, resume = 0;
    logic [4:0]  ep = 0;
    logic [7:0]  pin = 0;
    int          mismatches = 0, checks = 0, cyc = 0;
    // Last row is unmapped and reads zero
    ies_row_s    rows [6] = '{'{8'h10, 8'hA5, 8'hA5},
        '{8'h40, 8'h5A, 8'h5A}, '{8'h48, 8'h0F, 8'h0F},
        '{8'h51, 8'h3C, 8'h3C}, '{8'h2C, 8'h03, 8'h03},
        '{8'h33, 8'h77, 8'h00}};
    ies_if i_ies_if ();
    ies_device #(.T128_CYC(64), .T1024_CYC(128), .STARTUP_CYC(2000))
    i_ies_device (.ref_clk, .sys_rst, .fw(i_ies_if), .usb_se0(se0),
        .ep_hs(ep), .ep_hs_acked(acked), .hub_conn_chg(conn),
        .hub_babble(babble), .hub_resume(resume), .gpio_pin(pin),
        .i2c_byte_done(bdone), .i2c_first(first), .i2c_ack_in(ackin),
        .i2c_stop(istop), .i2c_arb_lost(arb), .i2c_proceed(proceed),
        .i2c_stop_req(stop_req), .startup_busy(busy));
    ies_ctrl i_ies_ctrl (.ref_clk, .sys_rst, .dv(i_ies_if),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_out,
        .irq_vec_out(irq_vec));
    ies_sva i_ies_sva (.ref_clk, .sys_rst, .reg_wr(i_ies_if.reg_wr),
        .reg_rd(i_ies_if.reg_rd), .reg_rvalid(i_ies_if.reg_rvalid),
        .irq(i_ies_if.irq), .irq_vec(i_ies_if.irq_vec));
    // 25 ns clock; ceiling far above the expected run
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (stop_req) stop_seen <= 1'b1;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic cy(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cy
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        awaddr <= {22'h0, a, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({6'h0, bresp}, 8'h00);
    endtask : wr
    task automatic rd(input logic [7:0] a, m, e);
        @(posedge ref_clk);
        araddr <= {22'h0, a, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk({6'h0, rresp}, 8'h00);
        chk(rdata[7:0] & m, e);
    endtask : rd
    initial begin
        cy(6);
        sys_rst <= 1'b0;
        chk({7'h0, busy}, 8'h01);
        rd(8'h20, 8'hFF, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, 8'hFF, rows[i].e);
        end
        // SE0 just short of the threshold, then a real bus reset
        wr(8'h20, 8'h01);
        se0 <= 1'b1;
        cy(470);
        se0 <= 1'b0;
        cy(4);
        rd(8'h1F, 8'h20, 8'h00);
        se0 <= 1'b1;
        cy(650);
        chk({7'h0, irq_out}, 8'h00);
        chk({7'h0, busy}, 8'h00);
        se0 <= 1'b0;
        cy(4);
        chk({4'h0, irq_vec}, 8'h01);
        rd(8'h1F, 8'h20, 8'h20);
        for (int i = 0; i < 4; i++) rd(rows[i].a, 8'hFF, 8'h00);
        wr(8'h24, 8'h01);
        wr(8'h20, 8'h06);
        cy(3);
        chk({4'h0, irq_vec}, 8'h02);
        rd(8'h22, 8'h06, 8'h06);
        wr(8'h20, 8'h00);
        // Unacked handshakes first, then acked ones
        ep <= 5'h1F;
        cy(1);
        ep <= 5'h00;
        rd(8'h22, 8'hF8, 8'h00);
        ep <= 5'h1F;
        acked <= 1'b1;
        cy(1);
        ep <= 5'h00;
        rd(8'h22, 8'hF8, 8'hF8);
        wr(8'h51, 8'h01);
        conn <= 4'h1;
        babble <= 4'h2;
        resume <= 4'h4;
        cy(1);
        conn <= 4'h0;
        babble <= 4'h0;
        resume <= 4'h0;
        rd(8'h23, 8'h01, 8'h00);
        conn <= 4'h2;
        cy(1);
        conn <= 4'h0;
        rd(8'h23, 8'h01, 8'h01);
        // Pin 0 takes the lock, pin 1 stays quiet until pin 0 lets go
        wr(8'h2D, 8'h01);
        pin <= 8'h01;
        rd(8'h23, 8'h04, 8'h04);
        wr(8'h24, 8'h0B);
        pin <= 8'h03;
        rd(8'h23, 8'h04, 8'h00);
        pin <= 8'h02;
        rd(8'h23, 8'h04, 8'h04);
        wr(8'h28, 8'h01);
        first <= 1'b1;
        ackin <= 1'b1;
        bdone <= 1'b1;
        cy(1);
        bdone <= 1'b0;
        cy(1);
        chk({7'h0, proceed}, 8'h00);
        rd(8'h29, 8'h09, 8'h09);
        istop <= 1'b1;
        cy(1);
        istop <= 1'b0;
        rd(8'h29, 8'h02, 8'h00);
        // With ack set the stop must be seen
        wr(8'h28, 8'h04);
        istop <= 1'b1;
        cy(1);
        istop <= 1'b0;
        rd(8'h29, 8'h02, 8'h02);
        wr(8'h28, 8'h02);
        wr(8'h28, 8'h00);
        // Stop pulse lands two edges after the write
        cy(2);
        chk({7'h0, stop_seen}, 8'h01);
        wr(8'h28, 8'h02);
        wr(8'h24, 8'h0C);
        arb <= 1'b1;
        cy(1);
        arb <= 1'b0;
        rd(8'h28, 8'h02, 8'h00);
        rd(8'h23, 8'h08, 8'h00);
        istop <= 1'b1;
        cy(1);
        istop <= 1'b0;
        rd(8'h23, 8'h08, 8'h08);
        conclude();
    end
endmodule : test_interrupt_event_sources
